// >>> shared/drive_input_pkg.sv
// Constants for the drive input function logic: register map, field
// positions, reset values, function codes and timing counts.
// Assumes a 250 MHz system clock and a 32-bit Avalon-MM register bus.
`default_nettype none
package drive_input_pkg;
	// ==========================================================
	// Clock and timing
	localparam int unsigned CLK_PERIOD_PS = 4000;
	localparam int unsigned DELAY_TICK_NS = 1000;
	localparam int unsigned TICK_CYCLES = (DELAY_TICK_NS * 1000) / CLK_PERIOD_PS;
	localparam int unsigned TICK_W = 8;
	localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_CYCLES - 1);

	// ==========================================================
	// Sizes
	localparam int unsigned N_INPUTS = 6;
	localparam int unsigned RAMP_W = 16;
	localparam int unsigned ADDR_W = 8;

	// ==========================================================
	// Register byte offsets
	localparam logic [ADDR_W-1:0] OFS_CONTROL = 8'h00;
	localparam logic [ADDR_W-1:0] OFS_POLARITY = 8'h04;
	localparam logic [ADDR_W-1:0] OFS_FSEL_LO = 8'h08;
	localparam logic [ADDR_W-1:0] OFS_FSEL_HI = 8'h0c;
	localparam logic [ADDR_W-1:0] OFS_ACCEL1 = 8'h10;
	localparam logic [ADDR_W-1:0] OFS_DECEL1 = 8'h14;
	localparam logic [ADDR_W-1:0] OFS_ACCEL2 = 8'h18;
	localparam logic [ADDR_W-1:0] OFS_DECEL2 = 8'h1c;
	localparam logic [ADDR_W-1:0] OFS_COAST_DELAY = 8'h20;
	localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h24;
	localparam logic [ADDR_W-1:0] OFS_IRQ_STATUS = 8'h28;
	localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 8'h2c;

	// ==========================================================
	// Control register fields
	localparam int unsigned CTL_KEYPAD_RESET = 0;
	localparam int unsigned CTL_GUARD_EN = 1;
	localparam int unsigned CTL_RESTART_MODE = 2;
	localparam int unsigned CTL_METHOD_LSB = 8;
	localparam logic [7:0] METHOD_TERMINAL = 8'h00;
	localparam logic [31:0] CONTROL_RESET = 32'h0000_0000;

	// Status register fields
	localparam int unsigned ST_OUT_ON = 0;
	localparam int unsigned ST_COASTING = 1;
	localparam int unsigned ST_TRIPPED = 2;
	localparam int unsigned ST_SECOND_RATE = 3;
	localparam int unsigned ST_WAITING = 4;
	localparam int unsigned ST_GUARD_HOLD = 5;
	localparam int unsigned ST_CODE_LSB = 8;

	// Interrupt bits
	localparam int unsigned IRQ_W = 3;
	localparam int unsigned IRQ_TRIP = 0;
	localparam int unsigned IRQ_COAST = 1;
	localparam int unsigned IRQ_RESUME = 2;

	// ==========================================================
	// Function codes and error codes
	localparam logic [7:0] FN_TWO_STAGE = 8'h09;
	localparam logic [7:0] FN_COAST = 8'h0b;
	localparam logic [7:0] FN_EXT_FAULT = 8'h0c;
	localparam logic [7:0] FN_FAULT_CLEAR = 8'h12;
	localparam logic [7:0] FN_NONE = 8'hff;
	localparam logic [7:0] ERR_NONE = 8'h00;
	localparam logic [7:0] ERR_EXT_TRIP = 8'h0c;

	// Reset values of the settings
	localparam logic [RAMP_W-1:0] RAMP_RESET = 16'h0064;
	localparam logic [15:0] COAST_DELAY_RESET = 16'h0000;

	// ==========================================================
	// Drive sequence states
	typedef enum logic [4:0] {
		S_STOP = 5'b00001,
		S_RUN = 5'b00010,
		S_COAST = 5'b00100,
		S_WAIT = 5'b01000,
		S_TRIP = 5'b10000
	} drive_state_t;
endpackage
`default_nettype wire

// >>> src/drive_input_function_logic.sv
// Drive input function logic: decodes six assignable terminals into ramp
// select, coast stop, external fault and fault clear, and sequences output.
// Assumes terminals and run command are asynchronous pins, settings come
// over Avalon-MM, and the ramp generator reads the selected times directly.
//
// How it works
// - Ramp select on chooses second accel/decel times, off returns first times.
// - Ramp select acts only when the switch method equals the terminal code.
// - Ramp select mid-acceleration switches to the second rate at once.
// - Coast stop input turns the power output off; motor coasts freely.
// - On coast release output resumes only while run command is active.
// - Restart mode chooses restart from zero or from present motor speed.
// - Restart waits the programmed coast delay; zero delay means no wait.
// - Each terminal has its own polarity; inverted means active when low.
// - External fault rising edge latches trip, reports its code, stops output.
// - Fault falling edge does nothing; trip persists until reset clears it.
// - Latched trip raises alarm at once and lets motor coast.
// - Reset clears alarm and error; release with run active restarts drive.
// - With start guard on, restart after a trip latched outside stop needs new run edge or fresh reset.
// - Each terminal decodes its function code from its own select setting.
//
// The placing of the registers and the Avalon-MM slave port are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
module drive_input_function_logic
	import drive_input_pkg::*;
(
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// Avalon-MM slave
	input wire logic [ADDR_W-1:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	output logic [31:0] avs_readdata_o,
	output logic avs_waitrequest_o,
	// Terminals and run command
	input wire logic [N_INPUTS-1:0] terminal_i,
	input wire logic run_cmd_i,
	// Ramp generator and output stage
	output logic [RAMP_W-1:0] accel_time_o,
	output logic [RAMP_W-1:0] decel_time_o,
	output logic output_enable_o,
	output logic resume_from_speed_o,
	// Alarm and interrupt
	output logic alarm_o,
	output logic [7:0] error_code_o,
	output logic irq_o
);

	// ==========================================================
	// Settings and state
	logic [31:0] control_q;
	logic [N_INPUTS-1:0] polarity_q;
	logic [7:0] fsel_q [N_INPUTS];
	logic [RAMP_W-1:0] accel1_q, decel1_q, accel2_q, decel2_q;
	logic [15:0] coast_delay_q;
	logic [IRQ_W-1:0] irq_status_q, irq_mask_q;
	logic ack_q;
	logic [N_INPUTS-1:0] term_meta_q, term_sync_q;
	logic run_meta_q, run_sync_q, run_prev_q;
	logic ext_prev_q, clr_prev_q, keypad_prev_q;
	logic trip_q, guard_hold_q;
	drive_state_t state_q, state_d;
	logic [15:0] delay_cnt_q;
	logic [TICK_W-1:0] tick_cnt_q;
	logic [N_INPUTS-1:0] term_active;
	logic two_stage_any, coast_any, ext_any, clr_any;
	logic ramp_second, ext_rise, reset_active, reset_fall, run_rise;
	logic bus_wr, bus_rd, rd_load;
	logic [IRQ_W-1:0] irq_event;
	logic delay_done;

	// ==========================================================
	// Avalon-MM handshake: one wait cycle, then accept
	assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~ack_q;
	assign rd_load = avs_read_i & ~ack_q;
	assign bus_wr = avs_write_i & ack_q;
	assign bus_rd = avs_read_i & ack_q;

	// Ack toggles so back-to-back requests each see one wait cycle
	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
			ack_q <= 1'b0;
		else
			ack_q <= (avs_read_i | avs_write_i) & ~ack_q;
	end

	// Register writes; unmapped and read-only offsets ignore writes
	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
		begin
			control_q <= CONTROL_RESET;
			polarity_q <= '0;
			for (int i = 0; i < N_INPUTS; i++)
				fsel_q[i] <= FN_NONE;
			accel1_q <= RAMP_RESET;
			decel1_q <= RAMP_RESET;
			accel2_q <= RAMP_RESET;
			decel2_q <= RAMP_RESET;
			coast_delay_q <= COAST_DELAY_RESET;
			irq_mask_q <= '0;
		end
		else if (bus_wr)
		begin
			case (avs_address_i)
				OFS_CONTROL: control_q <= avs_writedata_i;
				OFS_POLARITY: polarity_q <= avs_writedata_i[N_INPUTS-1:0];
				OFS_FSEL_LO:
				begin
					for (int i = 0; i < 4; i++)
						fsel_q[i] <= avs_writedata_i[8*i +: 8];
				end
				OFS_FSEL_HI:
				begin
					for (int i = 0; i < 2; i++)
						fsel_q[4+i] <= avs_writedata_i[8*i +: 8];
				end
				OFS_ACCEL1: accel1_q <= avs_writedata_i[RAMP_W-1:0];
				OFS_DECEL1: decel1_q <= avs_writedata_i[RAMP_W-1:0];
				OFS_ACCEL2: accel2_q <= avs_writedata_i[RAMP_W-1:0];
				OFS_DECEL2: decel2_q <= avs_writedata_i[RAMP_W-1:0];
				OFS_COAST_DELAY: coast_delay_q <= avs_writedata_i[15:0];
				OFS_IRQ_MASK: irq_mask_q <= avs_writedata_i[IRQ_W-1:0];
				default: ;
			endcase
		end
	end

	// Read data loaded in the wait cycle so it already stands at the
	// accepting edge; unmapped reads zero
	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
			avs_readdata_o <= '0;
		else if (rd_load)
		begin
			case (avs_address_i)
				OFS_CONTROL: avs_readdata_o <= control_q;
				OFS_POLARITY: avs_readdata_o <= {26'h0, polarity_q};
				OFS_FSEL_LO: avs_readdata_o <= {fsel_q[3], fsel_q[2], fsel_q[1], fsel_q[0]};
				OFS_FSEL_HI: avs_readdata_o <= {16'h0, fsel_q[5], fsel_q[4]};
				OFS_ACCEL1: avs_readdata_o <= {16'h0, accel1_q};
				OFS_DECEL1: avs_readdata_o <= {16'h0, decel1_q};
				OFS_ACCEL2: avs_readdata_o <= {16'h0, accel2_q};
				OFS_DECEL2: avs_readdata_o <= {16'h0, decel2_q};
				OFS_COAST_DELAY: avs_readdata_o <= {16'h0, coast_delay_q};
				OFS_STATUS:
				begin
					avs_readdata_o <= '0;
					avs_readdata_o[ST_OUT_ON] <= output_enable_o;
					avs_readdata_o[ST_COASTING] <= (state_q == S_COAST);
					avs_readdata_o[ST_TRIPPED] <= trip_q;
					avs_readdata_o[ST_SECOND_RATE] <= ramp_second;
					avs_readdata_o[ST_WAITING] <= (state_q == S_WAIT);
					avs_readdata_o[ST_GUARD_HOLD] <= guard_hold_q;
					avs_readdata_o[ST_CODE_LSB +: 8] <= error_code_o;
				end
				// Include this cycle's events: the clear at acceptance drops them
				OFS_IRQ_STATUS: avs_readdata_o <= {29'h0, irq_status_q | irq_event};
				OFS_IRQ_MASK: avs_readdata_o <= {29'h0, irq_mask_q};
				default: avs_readdata_o <= '0;
			endcase
		end
	end

	// ==========================================================
	// Pin synchronisers; first stage feeds only the second
	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
		begin
			term_meta_q <= '0;
			term_sync_q <= '0;
			run_meta_q <= 1'b0;
			run_sync_q <= 1'b0;
		end
		else
		begin
			term_meta_q <= terminal_i;
			term_sync_q <= term_meta_q;
			run_meta_q <= run_cmd_i;
			run_sync_q <= run_meta_q;
		end
	end

	// Polarity, then per-terminal function decode; several terminals may
	// share a function, in which case any one of them asserts it
	always_comb
	begin
		term_active = term_sync_q ^ polarity_q;
		two_stage_any = 1'b0;
		coast_any = 1'b0;
		ext_any = 1'b0;
		clr_any = 1'b0;
		for (int i = 0; i < N_INPUTS; i++)
		begin
			two_stage_any |= term_active[i] & (fsel_q[i] == FN_TWO_STAGE);
			coast_any |= term_active[i] & (fsel_q[i] == FN_COAST);
			ext_any |= term_active[i] & (fsel_q[i] == FN_EXT_FAULT);
			clr_any |= term_active[i] & (fsel_q[i] == FN_FAULT_CLEAR);
		end
	end

	// ==========================================================
	// Ramp time selection, applied live so a ramp in progress changes rate
	assign ramp_second = two_stage_any &
		(control_q[CTL_METHOD_LSB +: 8] == METHOD_TERMINAL);

	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
		begin
			accel_time_o <= RAMP_RESET;
			decel_time_o <= RAMP_RESET;
		end
		else
		begin
			accel_time_o <= ramp_second ? accel2_q : accel1_q;
			decel_time_o <= ramp_second ? decel2_q : decel1_q;
		end
	end

	// ==========================================================
	// Edge detection on synchronised levels
	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
		begin
			ext_prev_q <= 1'b0;
			clr_prev_q <= 1'b0;
			keypad_prev_q <= 1'b0;
			run_prev_q <= 1'b0;
		end
		else
		begin
			ext_prev_q <= ext_any;
			clr_prev_q <= clr_any;
			keypad_prev_q <= control_q[CTL_KEYPAD_RESET];
			run_prev_q <= run_sync_q;
		end
	end

	assign ext_rise = ext_any & ~ext_prev_q;
	assign reset_active = clr_any | control_q[CTL_KEYPAD_RESET];
	assign reset_fall = (clr_prev_q & ~clr_any) |
		(keypad_prev_q & ~control_q[CTL_KEYPAD_RESET]);
	assign run_rise = run_sync_q & ~run_prev_q;

	// Trip latch; a new fault edge wins over a reset in the same cycle
	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
			trip_q <= 1'b0;
		else if (ext_rise)
			trip_q <= 1'b1;
		else if (reset_active)
			trip_q <= 1'b0;
	end

	// Start guard: after a trip latched outside S_STOP is cleared the run level alone cannot restart
	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
			guard_hold_q <= 1'b0;
		else if (trip_q && reset_active && control_q[CTL_GUARD_EN])
			guard_hold_q <= 1'b1;
		else if (!trip_q && (run_rise || (reset_fall && !guard_clearing_edge())))
			guard_hold_q <= 1'b0;
	end

	// The reset that cleared the trip also releases the guard only when the trip latched in S_STOP
	function automatic logic guard_clearing_edge();
		return (state_q == S_TRIP);
	endfunction

	// ==========================================================
	// Coast restart delay: 1 us ticks from a prescaler
	assign delay_done = (delay_cnt_q == 16'h0000);

	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
		begin
			tick_cnt_q <= '0;
			delay_cnt_q <= '0;
		end
		else if (state_q != S_WAIT)
		begin
			tick_cnt_q <= '0;
			delay_cnt_q <= coast_delay_q;
		end
		else if (tick_cnt_q == TICK_LAST)
		begin
			tick_cnt_q <= '0;
			if (!delay_done)
				delay_cnt_q <= delay_cnt_q - 16'h0001;
		end
		else
			tick_cnt_q <= tick_cnt_q + TICK_W'(1);
	end

	// ==========================================================
	// Output sequence
	always_comb
	begin
		state_d = state_q;
		case (state_q)
			S_STOP:
			begin
				if (run_sync_q && !trip_q && !guard_hold_q && !reset_active)
					state_d = S_RUN;
			end
			S_RUN:
			begin
				if (trip_q)
					state_d = S_TRIP;
				else if (coast_any)
					state_d = S_COAST;
				else if (!run_sync_q)
					state_d = S_STOP;
			end
			S_COAST:
			begin
				if (trip_q)
					state_d = S_TRIP;
				else if (!coast_any)
				begin
					if (!run_sync_q)
						state_d = S_STOP;
					else if (coast_delay_q == 16'h0000)
						state_d = S_RUN;
					else
						state_d = S_WAIT;
				end
			end
			S_WAIT:
			begin
				if (trip_q)
					state_d = S_TRIP;
				else if (coast_any)
					state_d = S_COAST;
				else if (!run_sync_q)
					state_d = S_STOP;
				else if (delay_done)
					state_d = S_RUN;
			end
			S_TRIP:
			begin
				if (!trip_q && !reset_active)
					state_d = S_STOP;
			end
			default: state_d = S_STOP;
		endcase
	end

	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
			state_q <= S_STOP;
		else
			state_q <= state_d;
	end

	// Output stage drive, restart point and alarm, all registered
	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
		begin
			output_enable_o <= 1'b0;
			resume_from_speed_o <= 1'b0;
			alarm_o <= 1'b0;
			error_code_o <= ERR_NONE;
		end
		else
		begin
			// Fault edge cuts power in the same cycle the alarm rises
			output_enable_o <= (state_d == S_RUN) && !ext_rise;
			if (state_d == S_RUN && state_q != S_RUN)
				resume_from_speed_o <= (state_q != S_STOP) &
					control_q[CTL_RESTART_MODE];
			alarm_o <= trip_q | ext_rise;
			error_code_o <= (trip_q | ext_rise) ? ERR_EXT_TRIP : ERR_NONE;
		end
	end

	// ==========================================================
	// Interrupts: sticky events, cleared by a status read; set wins
	assign irq_event[IRQ_TRIP] = ext_rise;
	assign irq_event[IRQ_COAST] = (state_d == S_COAST) && (state_q != S_COAST);
	assign irq_event[IRQ_RESUME] = (state_d == S_RUN) && (state_q != S_RUN) &&
		(state_q != S_STOP);

	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
			irq_status_q <= '0;
		else if (bus_rd && avs_address_i == OFS_IRQ_STATUS)
			irq_status_q <= irq_event;
		else
			irq_status_q <= irq_status_q | irq_event;
	end

	always_ff @(posedge clk_i)
	begin
		if (!rst_n_i)
			irq_o <= 1'b0;
		else
			irq_o <= |((irq_status_q | irq_event) & irq_mask_q);
	end

endmodule
`default_nettype wire

// >>> tb/drive_input_chk.sv
// Port checker for the drive input function logic.
// Assumes it is bound into the design top; one clock, synchronous reset.
`timescale 1ns/100ps
`default_nettype none
module drive_input_chk
	import drive_input_pkg::*;
(
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// Register bus
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic avs_waitrequest_o,
	// Drive side
	input wire logic run_cmd_i,
	input wire logic [RAMP_W-1:0] accel_time_o,
	input wire logic output_enable_o,
	input wire logic resume_from_speed_o,
	input wire logic alarm_o,
	input wire logic [7:0] error_code_o,
	input wire logic irq_o
);
	// ==========================================================
	// Shared clocking and reset gating
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!rst_n_i);

	// Request seen but not yet accepted
	sequence s_req_pending;
		(avs_read_i || avs_write_i) && avs_waitrequest_o;
	endsequence

	// Entry into the trip state
	sequence s_trip_entry;
		$rose(alarm_o);
	endsequence

	// ==========================================================
	// Bus handshake: at most one wait cycle, none when idle
	a_wait_one_cycle: assert property (s_req_pending |=> !avs_waitrequest_o)
		else $error("waitrequest held longer than one cycle");
	a_wait_idle_low: assert property (!(avs_read_i || avs_write_i) |-> !avs_waitrequest_o)
		else $error("waitrequest high without a request");

	// ==========================================================
	// Trip reporting and output shut-off
	a_trip_code_shown: assert property (alarm_o |-> error_code_o == ERR_EXT_TRIP)
		else $error("alarm without external trip code");
	a_code_clear_idle: assert property (!alarm_o |-> error_code_o == ERR_NONE)
		else $error("error code left without alarm");
	a_trip_output_off: assert property (s_trip_entry |-> !output_enable_o throughout alarm_o [*3])
		else $error("output on while tripped");

	// ==========================================================
	// Run command governs the power output
	a_run_drop_off: assert property ($fell(run_cmd_i) |-> ##[1:8] !output_enable_o)
		else $error("output kept on after run dropped");
	a_start_needs_run: assert property ($rose(output_enable_o) |-> $past(run_cmd_i, 2))
		else $error("output started without run command");
	a_resume_on_entry: assert property ($changed(resume_from_speed_o) |-> $rose(output_enable_o))
		else $error("resume flag changed outside a start");

	// ==========================================================
	// Values at the first edge after reset release
	a_reset_values: assert property ($past(rst_n_i) == 1'b0 |->
		!output_enable_o && !alarm_o && !irq_o && accel_time_o == RAMP_RESET)
		else $error("outputs not at reset values after reset");
endmodule

bind drive_input_function_logic drive_input_chk drive_input_chk_i (
	.clk_i(clk_i),
	.rst_n_i(rst_n_i),
	.avs_read_i(avs_read_i),
	.avs_write_i(avs_write_i),
	.avs_waitrequest_o(avs_waitrequest_o),
	.run_cmd_i(run_cmd_i),
	.accel_time_o(accel_time_o),
	.output_enable_o(output_enable_o),
	.resume_from_speed_o(resume_from_speed_o),
	.alarm_o(alarm_o),
	.error_code_o(error_code_o),
	.irq_o(irq_o)
);
`default_nettype wire

// >>> tb/switch_bank_model.sv
// Model of the external switch bank and run contact.
// Assumes the bench says which functions are on; wiring inversion per input.
`timescale 1ns/100ps
`default_nettype none
module switch_bank_model
	import drive_input_pkg::*;
(
	// Clock
	input wire logic clk_i,
	// Requests from the bench
	input wire logic [N_INPUTS-1:0] fn_on_i,
	input wire logic [N_INPUTS-1:0] pol_i,
	input wire logic run_req_i,
	// Pins toward the drive
	output logic [N_INPUTS-1:0] terminal_o,
	output logic run_cmd_o
);
	// Contacts move just after an edge; normally-closed wiring inverts
	always_ff @(posedge clk_i)
	begin
		terminal_o <= fn_on_i ^ pol_i;
		run_cmd_o <= run_req_i;
	end
endmodule
`default_nettype wire

// >>> tb/test_drive_input_function_logic.sv
// Self-checking bench for the drive input function logic.
// Assumes the switch bank model and the bound port checker.
`timescale 1ns/100ps
`default_nettype none
module test_drive_input_function_logic
	import drive_input_pkg::*;
;
	// ==========================================================
	// Signals
	logic clk, rst_n, rd, wr, wreq, run_req, run_pin, oe, res, alarm, irq;
	logic [7:0] addr, code;
	logic [31:0] wdata, rdata;
	logic [5:0] fn_on, pol, term;
	logic [15:0] acc, dec;
	int error_cnt = 0;
	int total_checks = 0;

	drive_input_function_logic drive_input_function_logic_i (.clk_i(clk), .rst_n_i(rst_n),
		.avs_address_i(addr), .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdata),
		.avs_readdata_o(rdata), .avs_waitrequest_o(wreq), .terminal_i(term),
		.run_cmd_i(run_pin), .accel_time_o(acc), .decel_time_o(dec), .output_enable_o(oe),
		.resume_from_speed_o(res), .alarm_o(alarm), .error_code_o(code), .irq_o(irq));
	switch_bank_model switch_bank_model_i (.clk_i(clk), .fn_on_i(fn_on), .pol_i(pol),
		.run_req_i(run_req), .terminal_o(term), .run_cmd_o(run_pin));

	// ==========================================================
	// Helpers
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// Request held until waitrequest is sampled low
	task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		do @(posedge clk); while (wreq !== 1'b0);
		wr <= 1'b0;
	endtask
	// Read data stands at the accepting edge and is taken there
	task automatic bus_rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		do @(posedge clk); while (wreq !== 1'b0);
		d = rdata;
		rd <= 1'b0;
	endtask
	task automatic settle(input int n);
		repeat (n) @(posedge clk);
		@(negedge clk);
	endtask
	task automatic set_fn(input int i, input logic v);
		@(posedge clk);
		fn_on[i] <= v;
	endtask
	task automatic set_run(input logic v);
		@(posedge clk);
		run_req <= v;
	endtask
	// Bounded wait for the power output to reach a level
	task automatic wait_oe(input logic v, output int n);
		n = 0;
		while (oe !== v && n < 3000)
		begin
			@(negedge clk);
			n++;
		end
	endtask

	// ==========================================================
	// Scenarios
	task automatic t_regs();
		logic [31:0] d;
		bus_rd(OFS_ACCEL1, d);
		chk("accel1 reset", d, 32'h0000_0064);
		bus_rd(OFS_CONTROL, d);
		chk("control reset", d, 32'h0000_0000);
		bus_rd(8'h40, d);
		chk("unmapped read", d, 32'h0000_0000);
		bus_wr(OFS_STATUS, 32'hffff_ffff);
		bus_rd(OFS_STATUS, d);
		chk("status read only", d, 32'h0000_0000);
		// Inputs 0..3: ramp select, coast, fault, clear; coast wired inverted
		bus_wr(OFS_FSEL_LO, {FN_FAULT_CLEAR, FN_EXT_FAULT, FN_COAST, FN_TWO_STAGE});
		bus_wr(OFS_POLARITY, 32'h0000_0002);
		bus_wr(OFS_ACCEL2, 32'h0000_0200);
		bus_wr(OFS_DECEL2, 32'h0000_0300);
		bus_rd(OFS_ACCEL2, d);
		chk("accel2 readback", d, 32'h0000_0200);
		$display("test regs done");
	endtask
	task automatic t_ramp();
		int n;
		set_run(1'b1);
		wait_oe(1'b1, n);
		chk("start", 32'(oe), 32'h1);
		set_fn(0, 1'b1);
		settle(8);
		chk("accel second", 32'(acc), 32'h0200);
		chk("decel second", 32'(dec), 32'h0300);
		set_fn(0, 1'b0);
		settle(8);
		chk("accel first", 32'(acc), 32'h0064);
		// Non-terminal switch method must ignore the terminal
		bus_wr(OFS_CONTROL, 32'h0000_0100);
		set_fn(0, 1'b1);
		settle(8);
		chk("accel ignored", 32'(acc), 32'h0064);
		set_fn(0, 1'b0);
		bus_wr(OFS_CONTROL, 32'h0000_0000);
		$display("test ramp done");
	endtask
	task automatic t_coast();
		int n;
		set_fn(1, 1'b1);
		settle(8);
		chk("coast off", 32'(oe), 32'h0);
		set_fn(1, 1'b0);
		wait_oe(1'b1, n);
		chk("no delay", 32'(n < 40), 32'h1);
		chk("from zero", 32'(res), 32'h0);
		bus_wr(OFS_COAST_DELAY, 32'h0000_0002);
		bus_wr(OFS_CONTROL, 32'h0000_0004);
		set_fn(1, 1'b1);
		settle(8);
		set_fn(1, 1'b0);
		wait_oe(1'b1, n);
		chk("delay held", 32'(n >= 500 && n < 560), 32'h1);
		chk("from speed", 32'(res), 32'h1);
		// Release without run must leave the output off
		set_fn(1, 1'b1);
		settle(8);
		set_run(1'b0);
		settle(8);
		set_fn(1, 1'b0);
		settle(700);
		chk("stay off", 32'(oe), 32'h0);
		set_run(1'b1);
		wait_oe(1'b1, n);
		chk("start from stop", 32'(res), 32'h0);
		bus_wr(OFS_COAST_DELAY, 32'h0000_0000);
		bus_wr(OFS_CONTROL, 32'h0000_0000);
		$display("test coast done");
	endtask
	task automatic t_trip();
		logic [31:0] d;
		int n;
		bus_wr(OFS_IRQ_MASK, 32'h0000_0001);
		bus_rd(OFS_IRQ_STATUS, d);
		set_fn(2, 1'b1);
		settle(6);
		chk("alarm", 32'(alarm), 32'h1);
		chk("code", 32'(code), 32'(ERR_EXT_TRIP));
		chk("trip off", 32'(oe), 32'h0);
		chk("irq up", 32'(irq), 32'h1);
		set_fn(2, 1'b0);
		settle(10);
		chk("alarm kept", 32'(alarm), 32'h1);
		bus_rd(OFS_IRQ_STATUS, d);
		chk("trip event", 32'(d[IRQ_TRIP]), 32'h1);
		settle(2);
		chk("irq cleared", 32'(irq), 32'h0);
		set_fn(3, 1'b1);
		settle(6);
		chk("alarm cleared", 32'(alarm), 32'h0);
		chk("code cleared", 32'(code), 32'h0);
		set_fn(3, 1'b0);
		wait_oe(1'b1, n);
		chk("restart", 32'(oe), 32'h1);
		$display("test trip done");
	endtask
	task automatic t_guard();
		logic [31:0] d;
		int n;
		bus_wr(OFS_IRQ_MASK, 32'h0000_0000);
		bus_wr(OFS_CONTROL, 32'h0000_0002);
		set_fn(2, 1'b1);
		settle(6);
		chk("guard alarm", 32'(alarm), 32'h1);
		chk("irq masked", 32'(irq), 32'h0);
		set_fn(2, 1'b0);
		bus_wr(OFS_CONTROL, 32'h0000_0003);
		settle(4);
		chk("keypad clear", 32'(alarm), 32'h0);
		bus_wr(OFS_CONTROL, 32'h0000_0002);
		settle(40);
		chk("guard hold", 32'(oe), 32'h0);
		set_run(1'b0);
		settle(8);
		set_run(1'b1);
		wait_oe(1'b1, n);
		chk("guard release", 32'(oe), 32'h1);
		bus_rd(OFS_IRQ_STATUS, d);
		$display("test guard done");
	endtask

	// ==========================================================
	// Closing, clock, watchdog and main sequence
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	initial
	begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	// Tests need about 1500 cycles; allow far more
	initial
	begin
		#120000;
		error_cnt++;
		$display("watchdog expired");
		end_of_test();
	end
	initial
	begin
		rst_n = 1'b0;
		rd = 1'b0;
		wr = 1'b0;
		addr = 8'h00;
		wdata = 32'h0000_0000;
		fn_on = 6'h00;
		pol = 6'h02;
		run_req = 1'b0;
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		t_regs();
		t_ramp();
		t_coast();
		t_trip();
		t_guard();
		end_of_test();
	end
endmodule
`default_nettype wire
